//--- hdl/row_clock_and_interrupt_flags.sv
// row clock output, end flags, interrupt pin, serial command port, apb registers
// Functional notes
// - Each memory row traversed emits one row clock period, 200 ms at 8 kHz.
// - Normally the row clock is high 175 ms then low 25 ms at the end of the row.
// - In cueing mode the row clock is high 109.37 us and low 15.63 us per row.
// - A record start keeps the row clock high one extra low-phase length first.
// - The row clock pin is open drain: pulled low or released.
// - The interrupt pin is open drain: pulled low when pending, else released.
// - Memory end or message end pulls the interrupt pin low until cleared.
// - Every operation ending on message end or memory end raises an interrupt.
// - A pending interrupt clears when the host starts the next serial transaction.
// - The interrupt status is shifted out to the host in every serial transaction, whatever the opcode.
// - Finishing the last memory row in record or playback sets the memory end flag.
// - The message end flag is set only in playback on a stored marker, never in record.
// - A row holds eight marker positions and detection resolves to one of them.
// - Serial input is sampled on rising clock edges, output shifted on falling edges.
// - The device answers on the serial port only while select is low.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "row_irq_defines.svh"
module row_clock_and_interrupt_flags
  import row_irq_pkg::*;
(
  input  wire logic        clk,              // system clock, 100 MHz
  input  wire logic        rst_n,            // synchronous reset, low
  input  wire logic        ce,               // clock enable, freezes all state
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb write
  input  wire logic [11:0] paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped address
  output logic             irq,              // level interrupt to cpu
  input  wire logic        ss_n,             // serial select, low
  input  wire logic        sclk,             // serial clock
  input  wire logic        mosi,             // serial data in
  output logic             miso_o,           // serial data out
  output logic             miso_oe,          // serial data out enable
  input  wire logic        row_pulse_out_i,  // row clock pin level
  output logic             row_pulse_out_o,  // row clock pin drive value
  output logic             row_pulse_out_oe, // row clock pin pull-down enable
  input  wire logic        irq_pin_i,        // interrupt pin level
  output logic             irq_pin_o,        // interrupt pin drive value
  output logic             irq_pin_oe,       // interrupt pin pull-down enable
  input  wire logic [7:0]  eom_marks,        // marker positions of current row
  output logic      [10:0] array_row         // current memory row
);
  typedef struct packed {
    op_type      op;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic        ss_prev;
    logic        sclk_prev;
    logic [7:0]  shift_in;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_out;
    logic        miso;
    logic        mem_flag;
    logic        msg_flag;
    logic [2:0]  eom_pos;
    logic [10:0] row_addr;
    logic [10:0] start_row;
    logic [15:0] rate_div;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic        ack;
    logic [31:0] rdata;
    logic        slverr;
    logic        start;
    logic        stop;
    logic        record;
    logic        cue;
  } main_state_type;

  localparam main_state_type M_RST = '{
    op:        OP_IDLE,
    sync1:     `SYNC_RESET,
    sync2:     `SYNC_RESET,
    ss_prev:   1'b1,
    start_row: `START_ROW_RESET,
    rate_div:  16'(`RATE_DIV_RESET),
    mask:      `MASK_RESET,
    default:   '0
  };

  main_state_type q;
  main_state_type d;
  row_timer_if    tif ();

  logic       ss_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       selected;
  logic       ev_mem;
  logic       ev_msg;
  logic       ev_any;
  logic [7:0] opcode;
  logic [2:0] stat_clr;
  logic       apb_setup;
  logic       apb_done;

  row_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .tif   (tif)
  );

  assign tif.start = q.start;
  assign tif.stop = q.stop;
  assign tif.record = q.record;
  assign tif.cue = q.cue;
  assign tif.rate_div = q.rate_div;

  // edges come from the second sync stage only
  assign selected = ~q.sync2[`SY_SS];
  assign ss_fall = q.ss_prev & ~q.sync2[`SY_SS];
  assign sclk_rise = ~q.sclk_prev & q.sync2[`SY_SCLK];
  assign sclk_fall = q.sclk_prev & ~q.sync2[`SY_SCLK];
  assign opcode = {q.shift_in[6:0], q.sync2[`SY_MOSI]};
  assign apb_setup = psel & penable & ~q.ack;
  assign apb_done = psel & penable & q.ack;
  assign ev_any = ev_mem | ev_msg;
  // clear only what the completing read returned, so late events survive
  assign stat_clr = (apb_done & ~pwrite & (paddr == `ADDR_STATUS)) ? q.rdata[2:0] : 3'h0;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.stop = 1'b0;
    ev_mem = 1'b0;
    ev_msg = 1'b0;
    d.sync1 = {irq_pin_i, row_pulse_out_i, mosi, sclk, ss_n};
    d.sync2 = q.sync1;
    d.ss_prev = q.sync2[`SY_SS];
    d.sclk_prev = q.sync2[`SY_SCLK];

    // operation progress
    if (q.op != OP_IDLE && tif.row_end) begin
      if (q.row_addr == `ROW_LAST) begin
        ev_mem = 1'b1;
      end else begin
        d.row_addr = q.row_addr + 11'h001;
      end
    end
    // marker check is playback only; record never looks
    if ((q.op == OP_PLAY || q.op == OP_CUE) && tif.seg_end
        && eom_marks[tif.seg_pos]) begin
      ev_msg = 1'b1;
      d.eom_pos = tif.seg_pos;
    end
    if (ev_any) begin
      d.op = OP_IDLE;
      d.stop = 1'b1;
    end

    // serial port
    if (ss_fall) begin
      d.shift_out = {6'h00, q.msg_flag, q.mem_flag};
      d.miso = q.mem_flag;
      d.bit_cnt = 3'h0;
      d.mem_flag = 1'b0;
      d.msg_flag = 1'b0;
    end else if (selected && sclk_rise) begin
      d.shift_in = opcode;
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == 3'h7) begin
        case (opcode)
          `OPC_PLAY: begin
            d.op = OP_PLAY;
            d.start = 1'b1;
            d.record = 1'b0;
            d.cue = 1'b0;
            d.row_addr = q.start_row;
          end
          `OPC_REC: begin
            d.op = OP_REC;
            d.start = 1'b1;
            d.record = 1'b1;
            d.cue = 1'b0;
            d.row_addr = q.start_row;
          end
          `OPC_CUE: begin
            d.op = OP_CUE;
            d.start = 1'b1;
            d.record = 1'b0;
            d.cue = 1'b1;
            d.row_addr = q.start_row;
          end
          `OPC_STOP: begin
            d.op = OP_IDLE;
            d.stop = 1'b1;
          end
          default: begin
            d.op = q.op;
          end
        endcase
      end
    end else if (selected && sclk_fall) begin
      d.miso = q.shift_out[1];
      d.shift_out = {1'b0, q.shift_out[7:1]};
    end
    // a set in the same cycle as the clear wins
    if (ev_mem) begin
      d.mem_flag = 1'b1;
    end
    if (ev_msg) begin
      d.msg_flag = 1'b1;
    end

    // cpu interrupt status
    d.stat = (q.stat & ~stat_clr)
           | {tif.row_end && q.op != OP_IDLE, ev_msg, ev_mem};

    // apb: one wait state so read data leaves a flop
    d.ack = apb_setup;
    if (apb_setup) begin
      d.slverr = 1'b0;
      d.rdata = 32'h0000_0000;
      case (paddr)
        `ADDR_RATE_DIV:  d.rdata = {16'h0000, q.rate_div};
        `ADDR_START_ROW: d.rdata = {21'h000000, q.start_row};
        `ADDR_STATUS:    d.rdata = {29'h00000000, q.stat};
        `ADDR_MASK:      d.rdata = {29'h00000000, q.mask};
        `ADDR_STATE:     d.rdata = {5'h00, q.row_addr, 6'h00,
                                    q.sync2[`SY_INT], q.sync2[`SY_RAC],
                                    q.cue, q.record, (q.op != OP_IDLE),
                                    q.eom_pos, q.msg_flag, q.mem_flag};
        default:         d.slverr = 1'b1;
      endcase
    end
    if (apb_done && pwrite) begin
      case (paddr)
        `ADDR_RATE_DIV:  d.rate_div = pwdata[15:0];
        `ADDR_START_ROW: d.start_row = pwdata[10:0];
        `ADDR_MASK:      d.mask = pwdata[2:0];
        default:         d.mask = q.mask;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= M_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ack;
  assign pslverr = q.ack & q.slverr;
  assign irq = |(q.stat & q.mask);
  assign miso_o = q.miso;
  assign miso_oe = selected;
  // open drain: only ever pull low, the pull-up gives high
  assign row_pulse_out_o = 1'b0;
  // the timer sees a stop one cycle late, so gate with the running state
  assign row_pulse_out_oe = tif.low_phase & (q.op != OP_IDLE);
  assign irq_pin_o = 1'b0;
  assign irq_pin_oe = q.mem_flag | q.msg_flag;
  assign array_row = q.row_addr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_row_end_low: assert property (
    tif.row_end && $past(ce) |-> !row_pulse_out_oe && $past(row_pulse_out_oe)
  ) else $error("row end not preceded by low phase");

  a_mem_end_sets: assert property (
    ce && q.op != OP_IDLE && tif.row_end && q.row_addr == `ROW_LAST
    |=> irq_pin_oe && q.mem_flag && q.op == OP_IDLE
  ) else $error("last row did not raise memory end");

  a_pin_holds: assert property (
    irq_pin_oe && !ss_fall |=> irq_pin_oe
  ) else $error("interrupt pin released without serial start");

  a_pin_clears: assert property (
    ce && ss_fall && !ev_any |=> !irq_pin_oe
  ) else $error("interrupt pin not cleared at serial start");

  a_no_rec_eom: assert property (
    q.op == OP_REC |-> !ev_msg
  ) else $error("message end seen during record");

  a_eom_position: assert property (
    ce && ev_msg |=> q.eom_pos == $past(tif.seg_pos) && q.msg_flag
  ) else $error("marker position not captured");

  a_op_ends_irq: assert property (
    ce && ev_any |=> q.op == OP_IDLE ##1 tif.low_phase == 1'b0 || irq_pin_oe
  ) else $error("operation end without interrupt");

  a_status_read: assert property (
    ce && ss_fall |=> miso_o == $past(q.mem_flag)
               && q.shift_out[1] == $past(q.msg_flag)
  ) else $error("status not presented at serial start");

  a_miso_idle: assert property (
    q.sync2[`SY_SS] |-> !miso_oe
  ) else $error("serial output driven while deselected");

  a_rec_extra: assert property (
    ce && q.start && q.record |=> !row_pulse_out_oe [*2]
  ) else $error("record start pulled row clock low");

  a_rac_od: assert property (
    row_pulse_out_oe |-> row_pulse_out_o == 1'b0 && q.op != OP_IDLE
  ) else $error("row clock low outside an operation");
endmodule

//--- hdl/row_irq_defines.svh
// constants for the row clock and interrupt flag block
`ifndef ROW_IRQ_DEFINES_SVH
`define ROW_IRQ_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define EIGHTH_NS 15625
`define ROW_HIGH_NS 175000000
`define ROW_LOW_NS 25000000
`define CUE_HIGH_NS 109370
`define CUE_LOW_NS 15630
`define ROW_SEG_EIGHTHS ((`ROW_LOW_NS + `EIGHTH_NS / 2) / `EIGHTH_NS)
`define CUE_SEG_EIGHTHS ((`CUE_LOW_NS + `EIGHTH_NS / 2) / `EIGHTH_NS)
`define HIGH_SEGS ((`ROW_HIGH_NS + `ROW_LOW_NS / 2) / `ROW_LOW_NS)
`define RATE_DIV_RESET (`EIGHTH_NS / `CLK_PERIOD_NS)
`define ROW_LAST 11'h7FF
`define START_ROW_RESET 11'h000
`define MASK_RESET 3'h0
`define ADDR_RATE_DIV 12'h000
`define ADDR_START_ROW 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_MASK 12'h00C
`define ADDR_STATE 12'h010
`define EV_MEM_END 0
`define EV_MSG_END 1
`define EV_ROW_END 2
`define SY_SS 0
`define SY_SCLK 1
`define SY_MOSI 2
`define SY_RAC 3
`define SY_INT 4
`define SYNC_RESET 5'h19
`define OPC_STOP 8'h01
`define OPC_PLAY 8'h02
`define OPC_REC 8'h03
`define OPC_CUE 8'h04
`define OPC_READ_IRQ 8'h05
`endif

//--- hdl/row_irq_pkg.sv
// types for the row clock and interrupt flag block
package row_irq_pkg;
  typedef enum logic [3:0] {
    OP_IDLE = 4'h1,
    OP_PLAY = 4'h2,
    OP_REC  = 4'h4,
    OP_CUE  = 4'h8
  } op_type;
  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_PRE  = 4'h2,
    T_HIGH = 4'h4,
    T_LOW  = 4'h8
  } tstate_type;
  typedef struct packed {
    tstate_type  state;
    logic [15:0] div_cnt;
    logic [10:0] seg_cnt;
    logic [2:0]  pos;
    logic [2:0]  seg_pos;
    logic        seg_end;
    logic        row_end;
    logic        cue;
  } timer_state_type;
endpackage

//--- hdl/row_timer_if.sv
// control and event signals between the flag logic and the row timer
`timescale 1ns/1ps
interface row_timer_if;
  logic        start;
  logic        stop;
  logic        record;
  logic        cue;
  logic [15:0] rate_div;
  logic        low_phase;
  logic        seg_end;
  logic        row_end;
  logic [2:0]  seg_pos;
  modport ctrl (output start, stop, record, cue, rate_div,
                input low_phase, seg_end, row_end, seg_pos);
  modport timer (input start, stop, record, cue, rate_div,
                 output low_phase, seg_end, row_end, seg_pos);
endinterface

//--- hdl/row_timer.sv
// row period generator: eight segments per row, last segment low
`timescale 1ns/1ps
`include "row_irq_defines.svh"
module row_timer
  import row_irq_pkg::*;
(
  input  wire logic   clk,   // system clock
  input  wire logic   rst_n, // synchronous reset, low
  input  wire logic   ce,    // clock enable
  row_timer_if.timer  tif    // control and events
);
  localparam timer_state_type T_RST = '{state: T_IDLE, default: '0};
  timer_state_type q;
  timer_state_type d;
  logic        tick;
  logic [10:0] seg_len;

  // one segment is an eighth of a row, so the rate divider scales all of it
  assign seg_len = q.cue ? 11'(`CUE_SEG_EIGHTHS) : 11'(`ROW_SEG_EIGHTHS);
  assign tick = ({16'h0000, q.div_cnt} + 32'h1) >= {16'h0000, tif.rate_div};

  always_comb begin
    d = q;
    d.seg_end = 1'b0;
    d.row_end = 1'b0;
    if (tif.stop) begin
      d.state = T_IDLE;
    end else if (tif.start) begin
      // record start holds high one extra low-phase length
      d.state = tif.record ? T_PRE : T_HIGH;
      d.cue = tif.cue;
      d.div_cnt = 16'h0000;
      d.seg_cnt = 11'h000;
      d.pos = 3'h0;
    end else if (q.state != T_IDLE) begin
      d.div_cnt = tick ? 16'h0000 : q.div_cnt + 16'h0001;
      if (tick) begin
        d.seg_cnt = q.seg_cnt + 11'h001;
        if (q.seg_cnt == seg_len - 11'h001) begin
          d.seg_cnt = 11'h000;
          d.seg_pos = q.pos;
          case (q.state)
            T_PRE: begin
              d.state = T_HIGH;
            end
            T_HIGH: begin
              d.seg_end = 1'b1;
              d.pos = q.pos + 3'h1;
              if (q.pos == 3'(`HIGH_SEGS - 1)) begin
                d.state = T_LOW;
              end
            end
            T_LOW: begin
              d.seg_end = 1'b1;
              d.row_end = 1'b1;
              d.pos = 3'h0;
              d.state = T_HIGH;
            end
            default: begin
              d.state = T_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= T_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign tif.low_phase = (q.state == T_LOW);
  assign tif.seg_end = q.seg_end;
  assign tif.row_end = q.row_end;
  assign tif.seg_pos = q.seg_pos;
endmodule

//--- verification/spi_host_model.sv
// host side of the serial command port
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clk,     // system clock
  output logic      ss_n,    // select, low
  output logic      sclk,    // serial clock
  output logic      mosi,    // data to device
  input  wire logic miso_o,  // device data
  input  wire logic miso_oe  // device drive enable
);
  logic last_q = 1'h0;
  // a released line shows the inverse of its last value, never a stale bit
  wire  line   = miso_oe ? miso_o : ~last_q;
  initial begin
    ss_n = 1'h1;
    sclk = 1'h0;
    mosi = 1'h0;
  end
  always @(posedge clk) if (miso_oe) last_q <= miso_o;
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // clock idles low between frames; opcode msb first, status lsb first
  task automatic xfer(input logic sel, input logic [7:0] op, output logic [7:0] st);
    st = 8'h00;
    @(posedge clk);
    ss_n <= ~sel;
    gap(6);
    for (int i = 7; i >= 0; i--) begin
      mosi <= op[i];
      gap(6);
      sclk <= 1'h1;
      gap(6);
      st[7 - i] = line;
      sclk <= 1'h0;
    end
    gap(6);
    ss_n <= 1'h1;
    mosi <= 1'h0;
    gap(6);
  endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench for the row clock and interrupt flag block
`timescale 1ns/1ps
`include "row_irq_defines.svh"
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, ss_n, sclk, mosi, miso_o, miso_oe;
  logic        row_o, row_oe, irq_o, irq_oe;
  logic [7:0]  marks;
  logic [10:0] array_row;
  int          error_cnt, checked;
  // external pull-ups on both open-drain pins
  wire         row_pin = row_oe ? row_o : 1'h1;
  wire         irq_pin = irq_oe ? irq_o : 1'h1;

  row_clock_and_interrupt_flags dut_u (
    .clk, .rst_n, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .ss_n, .sclk, .mosi, .miso_o, .miso_oe,
    .row_pulse_out_i(row_pin), .row_pulse_out_o(row_o), .row_pulse_out_oe(row_oe),
    .irq_pin_i(irq_pin), .irq_pin_o(irq_o), .irq_pin_oe(irq_oe),
    .eom_marks(marks), .array_row);
  spi_host_model host_u (.clk, .ss_n, .sclk, .mosi, .miso_o, .miso_oe);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk("pready", pready, 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'h0, a, 32'h0, d, e);
  endtask

  // counts cycles of the pin high, then low; row seen while low
  task automatic meas(output int hi, output int lo, output logic [10:0] row);
    hi = 0;
    lo = 0;
    while (row_pin === 1'h1 && hi < 40000) begin
      @(posedge clk);
      hi++;
    end
    row = array_row;
    while (row_pin === 1'h0 && lo < 40000) begin
      @(posedge clk);
      lo++;
    end
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_pin !== 1'h0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk("irq pin low", irq_pin, 1'h0);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic        e;
    rd(`ADDR_RATE_DIV, d);
    chk("rate_div", d, `RATE_DIV_RESET);
    rd(`ADDR_START_ROW, d);
    chk("start_row", d, 32'h0);
    rd(`ADDR_MASK, d);
    chk("mask", d, 32'h0);
    rd(`ADDR_STATUS, d);
    chk("status", d, 32'h0);
    apb(1'h0, 12'h014, 32'h0, d, e);
    chk("unmapped err", e, 1'h1);
    chk("unmapped data", d, 32'h0);
  endtask

  task automatic t_select();
    logic [7:0]  st;
    logic [31:0] d;
    host_u.xfer(1'h0, `OPC_PLAY, st);
    rd(`ADDR_STATE, d);
    chk("run unselected", d[5], 1'h0);
    chk("miso_oe", miso_oe, 1'h0);
    host_u.xfer(1'h1, `OPC_PLAY, st);
    rd(`ADDR_STATE, d);
    chk("run", d[5], 1'h1);
    host_u.xfer(1'h1, `OPC_STOP, st);
    rd(`ADDR_STATE, d);
    chk("stopped", d[5], 1'h0);
    chk("no irq on stop", irq_pin, 1'h1);
  endtask

  task automatic t_play();
    int          hi, lo;
    logic [10:0] row;
    logic [7:0]  st;
    logic [31:0] d;
    marks <= 8'h00;
    wr(`ADDR_RATE_DIV, 32'h1);
    wr(`ADDR_START_ROW, 32'h7FE);
    wr(`ADDR_MASK, 32'h1);
    host_u.xfer(1'h1, `OPC_PLAY, st);
    meas(hi, lo, row);
    chk("first high", hi >= 11166 && hi <= 11204, 1'h1);
    chk("low", lo, 1600);
    chk("row", row, 11'h7FE);
    meas(hi, lo, row);
    chk("period", hi + lo, 12800);
    chk("high", hi, 11200);
    chk("row", row, 11'h7FF);
    wait_irq();
    repeat (2) @(posedge clk);
    chk("irq", irq, 1'h1);
    host_u.xfer(1'h1, `OPC_READ_IRQ, st);
    chk("serial status", st[1:0], 2'h1);
    chk("pin cleared", irq_pin, 1'h1);
    rd(`ADDR_STATUS, d);
    chk("status", d[1:0], 2'h1);
    rd(`ADDR_STATE, d);
    chk("op stopped", d[5], 1'h0);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 1'h0);
  endtask

  task automatic t_record();
    int          hi, lo;
    logic [10:0] row;
    logic [7:0]  st;
    logic [31:0] d;
    marks <= 8'hFF;
    wr(`ADDR_START_ROW, 32'h7FF);
    wr(`ADDR_MASK, 32'h0);
    host_u.xfer(1'h1, `OPC_REC, st);
    meas(hi, lo, row);
    chk("record high", hi >= 12766 && hi <= 12804, 1'h1);
    chk("record low", lo, 1600);
    wait_irq();
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 1'h0);
    wr(`ADDR_MASK, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq unmasked", irq, 1'h1);
    rd(`ADDR_STATUS, d);
    chk("record status", d[1:0], 2'h1);
    host_u.xfer(1'h1, `OPC_READ_IRQ, st);
  endtask

  task automatic t_cue();
    int          hi, lo;
    logic [10:0] row;
    logic [7:0]  st;
    logic [31:0] d;
    marks <= 8'h00;
    wr(`ADDR_RATE_DIV, 32'h3);
    wr(`ADDR_START_ROW, 32'h7FE);
    host_u.xfer(1'h1, `OPC_CUE, st);
    meas(hi, lo, row);
    meas(hi, lo, row);
    chk("cue high", hi, 21);
    chk("cue low", lo, 3);
    wait_irq();
    host_u.xfer(1'h1, `OPC_READ_IRQ, st);
    rd(`ADDR_STATUS, d);
    marks <= 8'h20;
    wr(`ADDR_START_ROW, 32'h0);
    host_u.xfer(1'h1, `OPC_CUE, st);
    wait_irq();
    rd(`ADDR_STATE, d);
    chk("marker pos", d[4:2], 3'h5);
    chk("flags", d[1:0], 2'h2);
    rd(`ADDR_STATUS, d);
    chk("msg status", d[1:0], 2'h2);
    host_u.xfer(1'h1, `OPC_READ_IRQ, st);
    chk("serial msg", st[1:0], 2'h2);
    chk("pin cleared", irq_pin, 1'h1);
  endtask

  initial begin
    rst_n     = 1'h0;
    psel      = 1'h0;
    penable   = 1'h0;
    pwrite    = 1'h0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    marks     = 8'h00;
    error_cnt = 0;
    checked   = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_reset();
    t_select();
    t_play();
    t_record();
    t_cue();
    test_done();
  end

  // whole run needs about 42000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
